// >>> psb_pkg.sv
// Purpose: shared constants and types of the pipelined burst sram core
// Assumes: wide configuration, 32 data bits plus 4 parity bits
// Notes:   narrow configuration keeps only lanes 0 and 1

package psb_pkg;

  // geometry of the array word
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int LANE_W  = 9;
  localparam int WORD_W  = LANES * LANE_W;
  localparam int MEM_WORDS = 1 << ADDR_W;

  // burst counter
  localparam int BURST_W = 2;

  // write record queued toward the array: address, byte selects, word
  localparam int REC_W   = ADDR_W + LANES + WORD_W;
  localparam int FIFO_DEPTH = 4;

  // values after reset
  localparam logic [ADDR_W-1:0]  ADDR_RST = 19'h00000;
  localparam logic [BURST_W-1:0] STEP_RST = 2'h0;
  localparam logic [WORD_W-1:0]  WORD_RST = 36'h000000000;
  localparam logic [LANES-1:0]   SEL_RST  = 4'hF;

  // pipeline operation carried from command to data phase
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } psb_op_t;

endpackage

// >>> psb_core.sv
// Purpose: command decode, two-stage pipeline, burst counter and array
// Assumes: all inputs synchronous to clock; out_en_n is the only async pin
// Notes:   write data and byte selects are sampled on the data-phase edge

`timescale 1ns/10ps
`default_nettype none

module psb_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic [AW-1:0] nxt_wp;
  logic [AW-1:0] nxt_rp;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];

  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wp  = push ? AW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp  = pop ? AW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage is not reset; only the pointers decide what is valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule

module psb_core
  import psb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_gate_n,
  input  wire logic              read_not_write,
  input  wire logic              advance_or_load,
  input  wire logic              chip_sel_a_n,
  input  wire logic              chip_sel_b,
  input  wire logic              chip_sel_c_n,
  input  wire logic [LANES-1:0]  byte_write_sel_n,
  input  wire logic              burst_order_sel,
  input  wire logic              out_en_n,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic [LANES-1:0]  parity_pins_in,
  output logic [DATA_W-1:0]      dq_out,
  output logic [LANES-1:0]       parity_pins_out,
  output logic                   dq_oe
);

  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] old_w,
    input logic [WORD_W-1:0] new_w,
    input logic [LANES-1:0]  sel_n
  );
    lane_merge = old_w;
    for (int k = 0; k < LANES; k++) begin
      if (!sel_n[k]) begin
        lane_merge[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
      end
    end
  endfunction

  function automatic logic [ADDR_W-1:0] burst_addr(
    input logic [ADDR_W-1:0]  base,
    input logic [BURST_W-1:0] step,
    input logic               interleave
  );
    burst_addr = base;
    if (interleave) begin
      burst_addr[BURST_W-1:0] = base[BURST_W-1:0] ^ step;
    end else begin
      burst_addr[BURST_W-1:0] = BURST_W'(base[BURST_W-1:0] + step);
    end
  endfunction

  logic [WORD_W-1:0]  sram [0:MEM_WORDS-1];

  psb_op_t            s1_op_ff;
  psb_op_t            s2_op_ff;
  psb_op_t            dir_ff;
  logic [ADDR_W-1:0]  s1_addr_ff;
  logic [ADDR_W-1:0]  s2_addr_ff;
  logic [ADDR_W-1:0]  base_ff;
  logic [BURST_W-1:0] step_ff;
  logic [WORD_W-1:0]  dout_ff;
  logic               drive_ff;

  psb_op_t            nxt_s1_op;
  psb_op_t            nxt_s2_op;
  psb_op_t            nxt_dir;
  logic [ADDR_W-1:0]  nxt_s1_addr;
  logic [ADDR_W-1:0]  nxt_s2_addr;
  logic [ADDR_W-1:0]  nxt_base;
  logic [BURST_W-1:0] nxt_step;
  logic [WORD_W-1:0]  nxt_dout;
  logic               nxt_drive;

  logic               selected;
  logic               run;
  logic               rd_phase;
  logic               push;
  logic               fifo_rdy;
  logic               head_valid;
  logic [REC_W-1:0]   head_rec;
  logic [ADDR_W-1:0]  head_addr;
  logic [LANES-1:0]   head_sel_n;
  logic [WORD_W-1:0]  head_word;
  logic [WORD_W-1:0]  wr_word;
  logic               drain;

  assign selected = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
  // a full write queue stalls the core exactly like a suspended edge
  assign run      = !clk_gate_n && fifo_rdy;
  assign rd_phase = run && (s2_op_ff == OP_READ);
  assign push     = run && (s2_op_ff == OP_WRITE);
  assign {head_addr, head_sel_n, head_word} = head_rec;
  // single-port array: a read phase wins, the queue drains on other cycles
  assign drain    = head_valid && !rd_phase;

  for (genvar k = 0; k < LANES; k++) begin : g_lane
    // lanes 2 and 3 are left unused in the narrow configuration
    assign wr_word[k*LANE_W +: LANE_W] =
      {parity_pins_in[k], dq_in[k*BYTE_W +: BYTE_W]};
    assign dq_out[k*BYTE_W +: BYTE_W] = dout_ff[k*LANE_W +: BYTE_W];
    assign parity_pins_out[k] = dout_ff[k*LANE_W + BYTE_W];
  end

  // output enable stays asynchronous, so it gates the registered drive
  assign dq_oe = drive_ff && !out_en_n;

  psb_fifo #(
    .W (REC_W),
    .D (FIFO_DEPTH)
  ) u_wq (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   ({s2_addr_ff, byte_write_sel_n, wr_word}),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .out_data  (head_rec),
    .out_valid (head_valid),
    .out_ready (!rd_phase)
  );

  always_comb begin
    nxt_s1_op   = s1_op_ff;
    nxt_s1_addr = s1_addr_ff;
    nxt_s2_op   = s2_op_ff;
    nxt_s2_addr = s2_addr_ff;
    nxt_dir     = dir_ff;
    nxt_base    = base_ff;
    nxt_step    = step_ff;
    nxt_dout    = dout_ff;
    nxt_drive   = drive_ff;
    if (run) begin
      nxt_s2_op   = s1_op_ff;
      nxt_s2_addr = s1_addr_ff;
      if (!advance_or_load) begin
        if (selected) begin
          nxt_s1_op   = read_not_write ? OP_READ : OP_WRITE;
          nxt_s1_addr = addr_in;
          nxt_base    = addr_in;
          nxt_step    = STEP_RST;
          nxt_dir     = nxt_s1_op;
        end else begin
          nxt_s1_op = OP_IDLE;
          nxt_dir   = OP_IDLE;
        end
      end else if (dir_ff != OP_IDLE) begin
        nxt_step    = BURST_W'(step_ff + 1'b1);
        nxt_s1_addr = burst_addr(base_ff, nxt_step, burst_order_sel);
        nxt_s1_op   = dir_ff;
      end else begin
        nxt_s1_op = OP_IDLE;
      end
      // data phase of the command two accepted edges back
      nxt_drive = (s2_op_ff == OP_READ);
      if (s2_op_ff == OP_READ) begin
        nxt_dout = sram[s2_addr_ff];
        // the queue never holds more than one record, so the head suffices
        if (head_valid && head_addr == s2_addr_ff) begin
          nxt_dout = lane_merge(sram[s2_addr_ff], head_word, head_sel_n);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_op_ff   <= OP_IDLE;
      s2_op_ff   <= OP_IDLE;
      dir_ff     <= OP_IDLE;
      s1_addr_ff <= ADDR_RST;
      s2_addr_ff <= ADDR_RST;
      base_ff    <= ADDR_RST;
      step_ff    <= STEP_RST;
      dout_ff    <= WORD_RST;
      drive_ff   <= 1'b0;
    end else begin
      s1_op_ff   <= nxt_s1_op;
      s2_op_ff   <= nxt_s2_op;
      dir_ff     <= nxt_dir;
      s1_addr_ff <= nxt_s1_addr;
      s2_addr_ff <= nxt_s2_addr;
      base_ff    <= nxt_base;
      step_ff    <= nxt_step;
      dout_ff    <= nxt_dout;
      drive_ff   <= nxt_drive;
    end
  end

  // the array holds no reset; it is undefined until written
  always_ff @(posedge clock) begin
    if (drain) begin
      sram[head_addr] <= lane_merge(sram[head_addr], head_word, head_sel_n);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence load_rd_s;
    run && !advance_or_load && selected && read_not_write;
  endsequence

  sequence load_wr_s;
    run && !advance_or_load && selected && !read_not_write;
  endsequence

  sequence two_more_s;
    run ##1 run;
  endsequence

  a_load_read_drive: assert property (
    load_rd_s ##1 two_more_s |=> drive_ff)
    else $error("read data not driven two edges after load");

  a_load_write_push: assert property (
    load_wr_s ##1 two_more_s |-> push)
    else $error("write data not taken two edges after load");

  a_deselect_hiz: assert property (
    (run && !advance_or_load && !selected) ##1 two_more_s |=> !drive_ff)
    else $error("bus driven after deselect");

  a_idle_cycle_hiz: assert property (
    (run && advance_or_load && dir_ff == OP_IDLE) ##1 two_more_s
      |=> !drive_ff)
    else $error("bus driven after idle slot");

  a_suspend_hold: assert property (
    !run |=> $stable(s1_op_ff) && $stable(s2_op_ff) && $stable(step_ff)
      && $stable(dout_ff) && $stable(drive_ff))
    else $error("state changed on suspended edge");

  a_burst_step: assert property (
    (run && advance_or_load && dir_ff != OP_IDLE)
      |=> step_ff == BURST_W'($past(step_ff) + 1'b1) && s1_op_ff == dir_ff)
    else $error("burst counter or direction wrong");

  a_chip_sel: assert property (
    (run && !advance_or_load && !(!chip_sel_a_n && chip_sel_b
      && !chip_sel_c_n)) |=> s1_op_ff == OP_IDLE)
    else $error("operation started while deselected");

  a_interleave: assert property (
    (run && advance_or_load && burst_order_sel && dir_ff != OP_IDLE)
      |=> s1_addr_ff[1:0] == (base_ff[1:0] ^ step_ff))
    else $error("interleaved burst address wrong");

  a_linear: assert property (
    (run && advance_or_load && !burst_order_sel && dir_ff != OP_IDLE)
      |=> s1_addr_ff[1:0] == BURST_W'(base_ff[1:0] + step_ff))
    else $error("linear burst address wrong");

endmodule

`default_nettype wire

// >>> psb_host.sv
// Purpose: host model driving commands and checking each data phase
// Assumes: one st call per clock; words fully written before read
// Notes:   shadow pipeline shifts only on run edges, as the core does
`timescale 1ns/10ps
`default_nettype none
module psb_host
  import psb_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic [LANES-1:0]  parity_pins_out,
  input  wire logic              dq_oe,
  output logic                   clk_gate_n,
  output logic                   read_not_write,
  output logic                   advance_or_load,
  output logic                   chip_sel_a_n,
  output logic                   chip_sel_b,
  output logic                   chip_sel_c_n,
  output logic [LANES-1:0]       byte_write_sel_n,
  output logic                   burst_order_sel,
  output logic                   out_en_n,
  output logic [ADDR_W-1:0]      addr_in,
  output logic [DATA_W-1:0]      dq_in,
  output logic [LANES-1:0]       parity_pins_in
);
  typedef struct packed {
    psb_op_t           op;
    logic [ADDR_W-1:0] a;
    logic [WORD_W-1:0] d;
    logic [LANES-1:0]  b;
  } psb_ent_t;
  psb_ent_t          p1, p2, p3, n;
  logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [WORD_W-1:0] cw, ex;
  logic [LANES-1:0]  cb;
  logic [ADDR_W-1:0] base;
  logic [1:0]        stp;
  logic              open, dir, oe_q, bo_q;
  int                errors, comparisons;
  initial begin
    {p1, p2, p3} = '0;
    {open, oe_q, bo_q} = 3'h0;
    errors = 0;
    comparisons = 0;
    {clk_gate_n, read_not_write, advance_or_load} = 3'h0;
    {chip_sel_b, burst_order_sel, out_en_n} = 3'h0;
    {chip_sel_a_n, chip_sel_c_n} = 2'h3;
    byte_write_sel_n = 4'hF;
    addr_in = 19'h00000;
    {parity_pins_in, dq_in} = 36'h000000000;
  end
  task automatic chk(input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic st(input logic g, input logic al, input logic rw,
                    input logic [2:0] cs, input logic [ADDR_W-1:0] a,
                    input logic [WORD_W-1:0] d, input logic [LANES-1:0] b);
    @(posedge clock);
    if (!clk_gate_n) begin
      n = '0;
      if (!advance_or_load) begin
        open = ({chip_sel_a_n, chip_sel_b, chip_sel_c_n} == 3'h2);
        dir = read_not_write;
        base = addr_in;
        stp = 2'h0;
      end else begin
        stp = stp + 2'h1;
      end
      if (open) begin
        n.op = dir ? OP_READ : OP_WRITE;
        n.a = {base[ADDR_W-1:2],
               burst_order_sel ? base[1:0] ^ stp : base[1:0] + stp};
        n.d = cw;
        n.b = cb;
      end
      p3 = p2;
      p2 = p1;
      p1 = n;
      if (p3.op != OP_IDLE) ex = mem[p3.a];
      if (p3.op == OP_WRITE) begin
        for (int k = 0; k < LANES; k++) begin
          if (!p3.b[k]) begin
            ex[BYTE_W*k +: BYTE_W] = p3.d[BYTE_W*k +: BYTE_W];
            ex[DATA_W+k] = p3.d[DATA_W+k];
          end
        end
        mem[p3.a] = ex;
      end
    end
    clk_gate_n <= g;
    advance_or_load <= al;
    read_not_write <= rw;
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n} <= cs;
    addr_in <= a;
    out_en_n <= oe_q;
    burst_order_sel <= bo_q;
    cw = d;
    cb = b;
    if (p2.op == OP_WRITE) begin
      {parity_pins_in, dq_in} <= p2.d;
      byte_write_sel_n <= p2.b;
    end else begin
      {parity_pins_in, dq_in} <= ~{parity_pins_in, dq_in};
      byte_write_sel_n <= 4'hF;
    end
    #1;
    if (p3.op == OP_READ && !out_en_n) begin
      chk({35'h0, dq_oe}, 36'h1);
      chk({parity_pins_out, dq_out}, ex);
    end else begin
      chk({35'h0, dq_oe}, 36'h0);
    end
  endtask
endmodule
`default_nettype wire

// >>> psb_core_tb.sv
// Purpose: sequences of host commands against the sram core
// Assumes: host model checks every data phase itself
// Notes:   order pin only changes while the bus is idle
`timescale 1ns/10ps
`default_nettype none
module psb_core_tb
  import psb_pkg::*;
;
  localparam logic [2:0] SEL = 3'h2;
  logic              clock, rst_n, clk_gate_n, read_not_write, dq_oe;
  logic              advance_or_load, chip_sel_a_n, chip_sel_b;
  logic              chip_sel_c_n, burst_order_sel, out_en_n;
  logic [LANES-1:0]  byte_write_sel_n, parity_pins_in, parity_pins_out;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] dq_in, dq_out;
  int                cyc = 0;
  psb_core u_psb_core (
    .clock            (clock),
    .rst_n            (rst_n),
    .clk_gate_n       (clk_gate_n),
    .read_not_write   (read_not_write),
    .advance_or_load  (advance_or_load),
    .chip_sel_a_n     (chip_sel_a_n),
    .chip_sel_b       (chip_sel_b),
    .chip_sel_c_n     (chip_sel_c_n),
    .byte_write_sel_n (byte_write_sel_n),
    .burst_order_sel  (burst_order_sel),
    .out_en_n         (out_en_n),
    .addr_in          (addr_in),
    .dq_in            (dq_in),
    .parity_pins_in   (parity_pins_in),
    .dq_out           (dq_out),
    .parity_pins_out  (parity_pins_out),
    .dq_oe            (dq_oe)
  );
  psb_host u_psb_host (
    .clock            (clock),
    .dq_out           (dq_out),
    .parity_pins_out  (parity_pins_out),
    .dq_oe            (dq_oe),
    .clk_gate_n       (clk_gate_n),
    .read_not_write   (read_not_write),
    .advance_or_load  (advance_or_load),
    .chip_sel_a_n     (chip_sel_a_n),
    .chip_sel_b       (chip_sel_b),
    .chip_sel_c_n     (chip_sel_c_n),
    .byte_write_sel_n (byte_write_sel_n),
    .burst_order_sel  (burst_order_sel),
    .out_en_n         (out_en_n),
    .addr_in          (addr_in),
    .dq_in            (dq_in),
    .parity_pins_in   (parity_pins_in)
  );
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                    input logic [LANES-1:0] b);
    u_psb_host.st(1'b0, 1'b0, 1'b0, SEL, a, d, b);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    u_psb_host.st(1'b0, 1'b0, 1'b1, SEL, a, 36'h0, 4'hF);
  endtask
  task automatic adv(input logic rw, input logic [WORD_W-1:0] d);
    u_psb_host.st(1'b0, 1'b1, rw, SEL, 19'h7, d, 4'h0);
  endtask
  // load read with the given selects, suspended when g is high
  task automatic ds(input logic g, input logic [2:0] cs);
    u_psb_host.st(g, 1'b0, 1'b1, cs, 19'h7, 36'h0, 4'hF);
  endtask
  // three deselects drain the pipeline before the next test
  task automatic fl(input string s);
    repeat (3) ds(1'b0, 3'h6);
    $display("test %s done", s);
  endtask
  task automatic final_report;
    $display("comparisons %0d errors %0d", u_psb_host.comparisons,
             u_psb_host.errors);
    if (u_psb_host.errors == 0 && u_psb_host.comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      u_psb_host.errors++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    fl("reset");
    wr(19'h10, 36'h912345678, 4'h0);
    rd(19'h10);
    wr(19'h11, 36'hACAFEF00D, 4'h0);
    rd(19'h11);
    for (int k = 0; k < LANES; k++) begin
      wr(19'h10, 36'hFFFFFFFFF, ~(4'h1 << k));
      rd(19'h10);
    end
    wr(19'h11, 36'h000000000, 4'h5);
    wr(19'h11, 36'h5A5A5A5A5, 4'hF);
    rd(19'h11);
    fl("lanes");
    for (int m = 0; m < 2; m++) begin
      u_psb_host.bo_q = m[0];
      ds(1'b0, 3'h6);
      wr(19'h21, 36'h000000001, 4'h0);
      for (int i = 2; i < 9; i++) adv(1'b1, WORD_W'(i));
      rd(19'h21);
      for (int i = 0; i < 3; i++) adv(1'b0, 36'h0);
      rd(19'h22);
      fl("burst");
    end
    rd(19'h10);
    ds(1'b0, 3'h6);
    adv(1'b1, 36'h0);
    ds(1'b0, 3'h0);
    ds(1'b0, 3'h3);
    adv(1'b0, 36'h0);
    fl("select");
    rd(19'h11);
    ds(1'b1, SEL);
    rd(19'h10);
    ds(1'b0, 3'h6);
    ds(1'b1, SEL);
    ds(1'b1, SEL);
    fl("suspend");
    u_psb_host.oe_q = 1'b1;
    rd(19'h10);
    ds(1'b0, 3'h6);
    ds(1'b0, 3'h6);
    u_psb_host.oe_q = 1'b0;
    fl("enable");
    final_report();
  end
endmodule
`default_nettype wire
